// *** wdt_pkg.sv ***
// constants and register map of the 16-bit supervisory timer
// What this block does
// - ordinary timer mode or supervisory watchdog mode
// - refresh write reloads counter; overflow reloads it in watchdog or periodic mode
// - ordinary mode clocked by 32.768 kHz prescaled
// - control bit 5 enters watchdog mode
// - watchdog counts down from reload to zero
// - prescale 256 full reload gives 512 s
// - zero count raises reset or interrupt
// - watchdog mode locks reload and control writes
// - only power-on reset clears the watchdog
// - counter frozen while debug holds core
// - power-down stops counting only if bit 0
// - reload and count 16-bit, count read-only
// - refresh clears irq normally, restarts watchdog
// - control bit 1 selects interrupt over reset
// - prescale bits 3:2 select 1, 16, 256
// - bit 8 up, bit 7 enable, bit 6 periodic
package wdt_pkg;
  localparam int unsigned OSC_HZ          = 32768;
  localparam int unsigned MAX_TIMEOUT_S   = 512;
  localparam int unsigned MIN_TIMEOUT_MS  = 30;

  localparam logic [31:0] OFS_RELOAD  = 32'hffff0360;
  localparam logic [31:0] OFS_COUNT   = 32'hffff0364;
  localparam logic [31:0] OFS_CTRL    = 32'hffff0368;
  localparam logic [31:0] OFS_REFRESH = 32'hffff036c;

  localparam logic [15:0] RELOAD_RST  = 16'h3bf8;
  localparam logic [15:0] COUNT_RST   = 16'h3bf8;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'h01ef;

  localparam int unsigned BIT_DIR     = 8;
  localparam int unsigned BIT_EN      = 7;
  localparam int unsigned BIT_PERIOD  = 6;
  localparam int unsigned BIT_WDOG    = 5;
  localparam int unsigned BIT_SCALE   = 2;
  localparam int unsigned BIT_IRQSEL  = 1;
  localparam int unsigned BIT_PDOFF   = 0;

  localparam logic [1:0] SCALE_DIV1   = 2'h0;
  localparam logic [1:0] SCALE_DIV16  = 2'h1;
  localparam logic [1:0] SCALE_DIV256 = 2'h2;
  localparam logic [7:0] DIV16_LAST   = 8'h0f;
  localparam logic [7:0] DIV256_LAST  = 8'hff;

  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RELOAD,
    SEL_COUNT,
    SEL_CTRL,
    SEL_REFRESH
  } wdt_sel_t;
endpackage

// *** wdt_prescale.sv ***
// divide-by 1/16/256 stage on the low-power oscillator ticks
module wdt_prescale
  import wdt_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] scale_i,
  output logic            step_o
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       step;
  } wdt_pre_t;

  wdt_pre_t st;
  wdt_pre_t next_st;

  always_comb begin
    next_st      = st;
    next_st.step = 1'b0;
    if (tick_i) begin
      case (scale_i)
        SCALE_DIV1: begin
          next_st.step = 1'b1;
          next_st.cnt  = 8'h00;
        end
        SCALE_DIV16: begin
          next_st.step = (st.cnt[3:0] == DIV16_LAST[3:0]);
          next_st.cnt  = {4'h0, st.cnt[3:0] + 4'h1};
        end
        // divide-by-256 on a full reload sets the longest timeout
        SCALE_DIV256: begin
          next_st.step = (st.cnt == DIV256_LAST);
          next_st.cnt  = st.cnt + 8'h01;
        end
        // reserved code: hold, never step
        default: next_st.cnt = st.cnt;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign step_o = st.step;
endmodule // wdt_prescale

// *** wdt_top.sv ***
// 16-bit ordinary/watchdog timer with an axi4-lite register slave
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        osc_32k_i,
  input  wire logic        dbg_halt_i,
  input  wire logic        powerdown_i,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             timer_irq_o,
  output logic             wdog_reset_o
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [2:0]  osc_sync;
    logic [1:0]  dbg_sync;
    logic [1:0]  pd_sync;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_got;
    logic        w_got;
    wdt_sel_t    aw_sel;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] reload;
    logic [15:0] count;
    logic [15:0] ctrl;
    logic        irq;
    logic        rst_req;
  } wdt_state_t;

  wdt_state_t st;
  wdt_state_t next_st;

  logic       step;
  logic       osc_edge;
  logic       dbg_hold;
  logic       pd_stop;
  logic       active;
  logic       run;
  logic       wr_commit;
  logic       refresh_wr;
  logic       event_hit;
  logic [15:0] byte_mask;

  function automatic wdt_sel_t sel_of(input logic [31:0] addr);
    case (addr)
      OFS_RELOAD:  sel_of = SEL_RELOAD;
      OFS_COUNT:   sel_of = SEL_COUNT;
      OFS_CTRL:    sel_of = SEL_CTRL;
      OFS_REFRESH: sel_of = SEL_REFRESH;
      default:     sel_of = SEL_NONE;
    endcase
  endfunction

  // pins come from other domains; only stage two onward is read
  assign osc_edge = st.osc_sync[1] & ~st.osc_sync[2];
  assign dbg_hold = st.dbg_sync[1];
  assign pd_stop  = st.pd_sync[1] & st.ctrl[BIT_PDOFF];
  assign active   = st.ctrl[BIT_EN] | st.ctrl[BIT_WDOG];
  assign run      = active & ~dbg_hold & ~pd_stop;

  assign wr_commit  = st.aw_got & st.w_got & ~st.bvalid;
  assign refresh_wr = wr_commit & (st.aw_sel == SEL_REFRESH);
  assign byte_mask  = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};

  wdt_prescale u_prescale (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .tick_i  (osc_edge & run),
    .scale_i (st.ctrl[BIT_SCALE +: 2]),
    .step_o  (step)
  );

  // terminal count: zero going down, all ones going up
  always_comb begin
    if (st.ctrl[BIT_WDOG] || !st.ctrl[BIT_DIR]) begin
      event_hit = step & run & (st.count == 16'h0000);
    end else begin
      event_hit = step & run & (st.count == 16'hffff);
    end
  end

  always_comb begin
    next_st          = st;
    next_st.osc_sync = {st.osc_sync[1:0], osc_32k_i};
    next_st.dbg_sync = {st.dbg_sync[0], dbg_halt_i};
    next_st.pd_sync  = {st.pd_sync[0], powerdown_i};
    next_st.rst_req  = 1'b0;

    // counting
    if (step && run) begin
      if (st.ctrl[BIT_WDOG]) begin
        if (event_hit) begin
          next_st.count = st.reload;
        end else begin
          next_st.count = st.count - 16'h0001;
        end
      end else if (st.ctrl[BIT_DIR]) begin
        if (event_hit) begin
          next_st.count = st.ctrl[BIT_PERIOD] ? st.reload : 16'h0000;
        end else begin
          next_st.count = st.count + 16'h0001;
        end
      end else begin
        if (event_hit) begin
          next_st.count = st.ctrl[BIT_PERIOD] ? st.reload : 16'hffff;
        end else begin
          next_st.count = st.count - 16'h0001;
        end
      end
    end

    // irq level is cleared by refresh; a same-cycle event wins
    if (refresh_wr) begin
      next_st.irq   = 1'b0;
      next_st.count = st.reload;
    end
    if (event_hit) begin
      if (!st.ctrl[BIT_WDOG] || st.ctrl[BIT_IRQSEL]) begin
        next_st.irq = 1'b1;
      end else begin
        next_st.rst_req = 1'b1;
      end
    end

    // write address and data channels, taken in either order
    if (st.awready && s_axi_awvalid_i) begin
      next_st.aw_got = 1'b1;
      next_st.aw_sel = sel_of(s_axi_awaddr_i);
    end
    if (st.wready && s_axi_wvalid_i) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata_i[15:0];
      next_st.wstrb = s_axi_wstrb_i[1:0];
    end
    if (wr_commit) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = (st.aw_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // lock holds from entry until power-on reset only
      if (!st.ctrl[BIT_WDOG]) begin
        if (st.aw_sel == SEL_RELOAD) begin
          next_st.reload = (st.reload & ~byte_mask)
                         | (st.wdata & byte_mask);
        end
        if (st.aw_sel == SEL_CTRL) begin
          next_st.ctrl = (st.ctrl & ~(byte_mask & CTRL_WMASK))
                       | (st.wdata & byte_mask & CTRL_WMASK);
        end
      end
      // count is read-only: writes there are accepted and dropped
    end
    if (st.bvalid && s_axi_bready_i) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = ~next_st.aw_got & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_got & ~next_st.bvalid;

    // read channel
    if (st.arready && s_axi_arvalid_i) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      case (sel_of(s_axi_araddr_i))
        SEL_RELOAD:  next_st.rdata = {16'h0000, st.reload};
        SEL_COUNT:   next_st.rdata = {16'h0000, st.count};
        SEL_CTRL:    next_st.rdata = {16'h0000, st.ctrl};
        SEL_REFRESH: next_st.rdata = 32'h0000_0000;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && s_axi_rready_i) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = ~next_st.rvalid;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st        <= '0;
      st.reload <= RELOAD_RST;
      st.count  <= COUNT_RST;
      st.ctrl   <= CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready_o = st.awready;
  assign s_axi_wready_o  = st.wready;
  assign s_axi_bvalid_o  = st.bvalid;
  assign s_axi_bresp_o   = st.bresp;
  assign s_axi_arready_o = st.arready;
  assign s_axi_rvalid_o  = st.rvalid;
  assign s_axi_rdata_o   = st.rdata;
  assign s_axi_rresp_o   = st.rresp;
  assign timer_irq_o     = st.irq;
  assign wdog_reset_o    = st.rst_req;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_write_taken;
    st.aw_got && st.w_got && !st.bvalid;
  endsequence

  sequence s_wdog_zero;
    st.ctrl[BIT_WDOG] && event_hit;
  endsequence

  a_bus_write_resp: assert property (
    s_write_taken |=> st.bvalid ##0 !st.aw_got && !st.w_got)
    else $error("write not answered one cycle after both channels");

  a_lock_regs: assert property (
    st.ctrl[BIT_WDOG] |=> st.ctrl[BIT_WDOG] && $stable(st.reload)
                         && $stable(st.ctrl))
    else $error("control or reload changed while locked");

  a_refresh_reload: assert property (
    refresh_wr |=> st.count == $past(st.reload))
    else $error("refresh did not reload the counter");

  a_refresh_clears: assert property (
    refresh_wr && !event_hit |=> !st.irq)
    else $error("refresh did not clear the interrupt");

  a_debug_freeze: assert property (
    dbg_hold && !refresh_wr |=> $stable(st.count))
    else $error("counter moved during debug hold");

  a_pd_stop: assert property (
    pd_stop && !refresh_wr |=> $stable(st.count))
    else $error("counter moved in power-down with stop bit");

  a_wdog_reset: assert property (
    s_wdog_zero ##0 !st.ctrl[BIT_IRQSEL] |=> wdog_reset_o ##1 !wdog_reset_o)
    else $error("timeout reset not a one-cycle pulse");

  a_wdog_irq: assert property (
    s_wdog_zero ##0 st.ctrl[BIT_IRQSEL] |=> timer_irq_o && !wdog_reset_o)
    else $error("interrupt option did not raise the interrupt");

  a_wdog_down: assert property (
    st.ctrl[BIT_WDOG] && step && run && st.count != 16'h0000
      && !refresh_wr |=> st.count == $past(st.count) - 16'h0001)
    else $error("watchdog count did not decrement by one");

  a_irq_hold: assert property (
    st.irq && !refresh_wr |=> st.irq)
    else $error("interrupt dropped without refresh");

  a_normal_no_rst: assert property (
    !st.ctrl[BIT_WDOG] |=> !wdog_reset_o)
    else $error("reset request raised outside watchdog mode");

  a_wdog_reload: assert property (
    s_wdog_zero |=> st.count == $past(st.reload))
    else $error("timeout did not reload the counter");

  a_up_count: assert property (
    !st.ctrl[BIT_WDOG] && st.ctrl[BIT_DIR] && step && run
      && st.count != 16'hffff && !refresh_wr
      |=> st.count == $past(st.count) + 16'h0001)
    else $error("up count did not increment by one");

  a_free_wrap: assert property (
    !st.ctrl[BIT_WDOG] && !st.ctrl[BIT_DIR] && !st.ctrl[BIT_PERIOD]
      && event_hit && !refresh_wr |=> st.count == 16'hffff)
    else $error("free-running down count did not wrap");

  a_count_idle: assert property (
    !active && !refresh_wr |=> $stable(st.count))
    else $error("counter moved while disabled");

  a_write_okay: assert property (
    s_write_taken ##0 st.aw_sel != SEL_NONE
      |=> s_axi_bresp_o == RESP_OKAY)
    else $error("mapped write not answered okay");
endmodule // wdt_top

// *** wdt_partner.sv ***
// model of the core reset and interrupt controller
module wdt_partner (
  input  wire logic mclk_i,
  input  wire logic irq_i,
  input  wire logic wdog_reset_i,
  output int        n_resets_o,
  output int        n_irqs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   nr = 0;
  int   ni = 0;
  logic irq_q = 1'h0;
  assign n_resets_o = nr;
  assign n_irqs_o = ni;
  // counts high cycles, so a stretched pulse shows as extra resets
  always @(posedge mclk_i) begin
    if (wdog_reset_i === 1'h1) nr <= nr + 1;
    if (irq_i === 1'h1 && !irq_q) ni <= ni + 1;
    irq_q <= (irq_i === 1'h1);
  end
endmodule // wdt_partner

// *** testbench.sv ***
// self-checking bench of the supervisory timer
module testbench
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        osc = 1'h0;
  logic        dbg = 1'h0;
  logic        pd = 1'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        arvalid = 1'h0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic [31:0] rdata, d, r, c;
  logic [31:0] seed = 32'h7b8c;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, irq, wrst;
  int          n_rst, n_irq;
  int          mismatches = 0;
  int          n_checks = 0;

  always #10 clk = ~clk;

  wdt_top i_wdt_top (
    .mclk_i(clk), .rst_n_i(rst_n), .osc_32k_i(osc),
    .dbg_halt_i(dbg), .powerdown_i(pd),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'h1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'h1), .timer_irq_o(irq), .wdog_reset_o(wrst)
  );

  wdt_partner i_wdt_partner (
    .mclk_i(clk), .irq_i(irq), .wdog_reset_i(wrst),
    .n_resets_o(n_rst), .n_irqs_o(n_irq)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int div_of(int i);
    return (i == 1) ? 16 : (i == 2) ? 256 : 1;
  endfunction

  // 2*div ticks from a fresh prescaler give two steps; reserved scale and power-down stop give none
  function automatic logic [31:0] cnt_exp(int i, logic [31:0] v);
    if (i == 3 || i == 5) return v;
    return (i == 4) ? v + 2 : v - 2;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // bready and rready stay high, so no release race between calls
  task automatic wr(input logic [31:0] a, v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    resp = bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      osc <= 1'h1;
      repeat (4) @(posedge clk);
      osc <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic por();
    rst_n <= 1'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
  endtask

  initial begin
    por();
    rd(OFS_RELOAD);
    chk("reload rst", d, {16'h0, RELOAD_RST});
    rd(OFS_COUNT);
    chk("count rst", d, {16'h0, COUNT_RST});
    rd(32'hffff0370);
    chk("unmapped", resp, RESP_SLVERR);
    wr(OFS_COUNT, 32'h1234);
    chk("count wr resp", resp, RESP_OKAY);
    wr(32'hffff0370, rnd());
    chk("unmapped wr", resp, RESP_SLVERR);
    rd(OFS_COUNT);
    chk("count ro", d, {16'h0, COUNT_RST});
    r = rnd();
    wr(OFS_RELOAD, r);
    rd(OFS_RELOAD);
    chk("reload rw", d, r & 32'hffff);
    wr(OFS_CTRL, 32'hffdf);
    rd(OFS_CTRL);
    chk("ctrl bits", d, 32'h01cf);
    for (int i = 0; i < 6; i++) begin
      por();
      r = 32'h0100 + (rnd() & 32'h7fff);
      c = 32'h80 | ((i < 4 ? i : 0) << 2) | ((i == 4) << 8) | (i == 5);
      wr(OFS_RELOAD, r);
      wr(OFS_CTRL, c);
      pd <= (i == 5);
      wr(OFS_REFRESH, rnd());
      tick(2 * div_of(i));
      rd(OFS_COUNT);
      chk("count step", d, cnt_exp(i, r));
    end
    por();
    pd <= 1'h0;
    wr(OFS_RELOAD, 32'h2);
    wr(OFS_CTRL, 32'hc0);
    wr(OFS_REFRESH, 32'h0);
    tick(3);
    chk("irq set", irq, 1'h1);
    tick(2);
    chk("irq held", irq, 1'h1);
    chk("irq edges", n_irq, 1);
    wr(OFS_REFRESH, rnd());
    chk("irq clr", irq, 1'h0);
    chk("no rst", n_rst, 0);
    por();
    wr(OFS_RELOAD, 32'h1);
    wr(OFS_CTRL, 32'h80);
    wr(OFS_REFRESH, 32'h0);
    tick(2);
    rd(OFS_COUNT);
    chk("free wrap", d, 32'hffff);
    chk("wrap irq", irq, 1'h1);
    por();
    // tiny timeouts only to keep the run short; firmware keeps 30 ms
    wr(OFS_RELOAD, 32'h3);
    wr(OFS_CTRL, 32'h20);
    wr(OFS_REFRESH, 32'h0);
    pd <= 1'h1;
    tick(3);
    wr(OFS_REFRESH, rnd());
    tick(3);
    chk("no timeout", n_rst, 0);
    tick(1);
    chk("timeout rst", n_rst, 1);
    chk("no irq", irq, 1'h0);
    rd(OFS_COUNT);
    chk("reloaded", d, 32'h3);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_RELOAD, 32'h55);
    chk("lock wr resp", resp, RESP_OKAY);
    rd(OFS_CTRL);
    chk("ctrl lock", d, 32'h20);
    rd(OFS_RELOAD);
    chk("reload lock", d, 32'h3);
    dbg <= 1'h1;
    repeat (4) @(posedge clk);
    tick(2);
    rd(OFS_COUNT);
    chk("dbg freeze", d, 32'h3);
    dbg <= 1'h0;
    repeat (4) @(posedge clk);
    tick(1);
    rd(OFS_COUNT);
    chk("dbg resume", d, 32'h2);
    por();
    wr(OFS_RELOAD, 32'h1);
    wr(OFS_CTRL, 32'h22);
    wr(OFS_REFRESH, 32'h0);
    tick(2);
    chk("wdog irq", irq, 1'h1);
    chk("irq no rst", n_rst, 1);
    wr(OFS_REFRESH, 32'h0);
    chk("wdog irq clr", irq, 1'h0);
    test_done();
  end

  // whole run needs about 5000 cycles; this leaves ample slack
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule // testbench
